/* File: hw/sfid_pkg.sv */
// constants shared by the serial flash instruction decoder files
// assumes a system clock of 125 mhz and a host that clocks the link in spi mode 0 or 3
package sfid_pkg;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [7:0] SFID_OP_READ = 8'h03;
	localparam logic [7:0] SFID_OP_FAST_READ = 8'h0B;
	localparam logic [7:0] SFID_OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] SFID_OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] SFID_OP_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] SFID_OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] SFID_OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] SFID_OP_BYTE_PROG = 8'h02;
	localparam logic [7:0] SFID_OP_AUTO_INC = 8'hAD;
	localparam logic [7:0] SFID_OP_STATUS_READ = 8'h05;
	localparam logic [7:0] SFID_OP_STATUS_UNLOCK = 8'h50;
	localparam logic [7:0] SFID_OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] SFID_OP_LATCH_SET = 8'h06;
	localparam logic [7:0] SFID_OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] SFID_OP_IDENT_A = 8'h90;
	localparam logic [7:0] SFID_OP_IDENT_B = 8'hAB;
	localparam logic [7:0] SFID_OP_BUSY_OUT_ON = 8'h70;
	localparam logic [7:0] SFID_OP_BUSY_OUT_OFF = 8'h80;
	// ****************************************
	// framing and field layout
	// ****************************************
	localparam int SFID_BYTE_BITS = 8;
	localparam logic [2:0] SFID_LAST_BIT = 3'h7;
	localparam logic [2:0] SFID_ADDR_BYTES = 3'h3;
	localparam int SFID_ADDR_W = 24;
	localparam int SFID_SECTOR_LSB = 12;
	localparam int SFID_BLOCK32_LSB = 15;
	localparam int SFID_BLOCK64_LSB = 16;
	localparam logic [7:0] SFID_FILL_BYTE = 8'hFF;
	// status byte bit positions
	localparam int SFID_ST_BUSY = 0;
	localparam int SFID_ST_LATCH = 1;
	localparam int SFID_ST_BP_LSB = 2;
	localparam int SFID_ST_AUTO = 6;
	localparam int SFID_ST_LOCK = 7;
	localparam logic [3:0] SFID_BP_RESET = 4'h7;
	// erase kinds reported to the array
	typedef enum logic [1:0] {
		SFID_ER_SECTOR,
		SFID_ER_BLOCK32,
		SFID_ER_BLOCK64,
		SFID_ER_CHIP
	} sfid_erase_e;
	// ****************************************
	// timing
	// ****************************************
	localparam int SFID_CLK_MHZ = 125;
	localparam int SFID_SYNC_STAGES = 2;
endpackage

/* File: hw/sfid_sync.sv */
// two flip-flop level synchroniser into the system clock domain
// assumes the input is a level that stays put for several destination clocks
module sfid_sync
	import sfid_pkg::*;
#(
	parameter logic INIT = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic d_in,
	output logic q_out
);
	typedef struct packed {
		logic meta; // first stage, read only by the second
		logic q; // settled copy
	} sfid_sync_s;
	sfid_sync_s st_reg;
	sfid_sync_s st_next;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next.meta = d_in;
		st_next.q = st_reg.meta;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= {INIT, INIT};
		end else begin
			st_reg <= st_next;
		end
	end
	assign q_out = st_reg.q;
endmodule

/* File: hw/sfid_link.sv */
// serial side of the decoder, clocked by the host serial clock
// assumes chip select high clears the whole link side; words from the system side are
// held stable for many serial clocks before they are loaded
module sfid_link
	import sfid_pkg::*;
(
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic [7:0] status_in,
	output logic [7:0] rx_byte_out,
	output logic rx_tgl_out,
	output logic mid_byte_out,
	output logic so_out
);
	typedef struct packed {
		logic [2:0] bit_cnt; // bits of the current bus cycle
		logic [7:0] shreg; // incoming bits
		logic [7:0] rx_byte; // last whole byte
		logic rx_tgl; // flips once per whole byte
		logic first; // no byte yet in this frame
		logic mid; // partial byte in progress, registered so the crossing sees no glitch
		logic [7:0] tx_shift; // outgoing bits, msb first
	} sfid_link_s;
	sfid_link_s st_reg;
	sfid_link_s st_next;
	logic so_reg;

	// ****************************************
	// shift on rising serial clock
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.shreg = {st_reg.shreg[6:0], si_in};
		st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
		st_next.tx_shift = {st_reg.tx_shift[6:0], 1'b0};
		st_next.mid = (st_reg.bit_cnt != SFID_LAST_BIT);
		if (st_reg.bit_cnt == SFID_LAST_BIT) begin
			// eighth bit closes the bus cycle
			st_next.rx_byte = {st_reg.shreg[6:0], si_in};
			st_next.rx_tgl = ~st_reg.rx_tgl;
			st_next.first = 1'b0;
			// status answers right after its opcode, too soon for the system side
			if (st_reg.first && {st_reg.shreg[6:0], si_in} == SFID_OP_STATUS_READ) begin
				st_next.tx_shift = status_in;
			end else begin
				st_next.tx_shift = tx_byte_in;
			end
		end
	end

	// chip select high is the frame's own end, so it clears the link side
	always_ff @(posedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			st_reg <= '{bit_cnt: 3'h0, shreg: 8'h00, rx_byte: 8'h00, rx_tgl: 1'b0,
				first: 1'b1, mid: 1'b0, tx_shift: 8'h00};
		end else begin
			st_reg <= st_next;
		end
	end

	// output changes on the falling edge so the host samples a settled bit
	always_ff @(negedge sck_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			so_reg <= 1'b0;
		end else begin
			so_reg <= st_reg.tx_shift[7];
		end
	end

	assign rx_byte_out = st_reg.rx_byte;
	assign rx_tgl_out = st_reg.rx_tgl;
	assign mid_byte_out = st_reg.mid;
	assign so_out = so_reg;
endmodule

/* File: hw/sfid_decoder.sv */
// instruction decoder of a serial nor flash front end
// assumes the array behind it reports busy, answers a read one clock after the request,
// and performs erase and program requests on its own
module sfid_decoder
	import sfid_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
	parameter int ADDR_W = SFID_ADDR_W
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic wp_n_in,
	input wire logic busy_in,
	input wire logic [7:0] mem_rd_data_in,
	output logic so_out,
	output logic so_oe_out,
	output logic mem_rd_req_out,
	output logic [ADDR_W-1:0] mem_addr_out,
	output logic prog_req_out,
	output logic [7:0] prog_data_out,
	output logic erase_req_out,
	output logic [1:0] erase_kind_out,
	output logic write_enable_latch_out,
	output logic [7:0] status_out
);
// Notes on behaviour
// - every bus cycle is eight serial clocks
// - framing starts on chip select falling
// - sample input on rising clock, msb first
// - early deselect abandons the instruction
// - read 03h, fast read 0bh with dummy
// - 20h erases sector, address bits above 12
// - 52h erases block, address bits above 15
// - d8h erases block, address bits above 16
// - 60h or c7h erases whole array
// - 02h programs one byte at address
// - adh programs word pairs, even then odd
// - 05h repeats status until deselect
// - 70h enables busy report on output
// - 80h disables busy report outside word programming
// - 90h or abh reads ids by bit 0
// - address bits above array width ignored
// - write latch clears after write instructions except adh
// - status write refused when pin low, locked

	typedef enum logic [2:0] {
		SFID_IDLE, // between frames
		SFID_ADDR, // collecting address bytes
		SFID_DUMMY, // fast read dummy byte
		SFID_DATA, // write data bytes
		SFID_OUT, // streaming output
		SFID_IGNORE // nothing more this frame
	} sfid_state_e;

	typedef struct packed {
		sfid_state_e state;
		logic [7:0] opcode; // instruction of this frame
		logic [ADDR_W-1:0] addr; // working address
		logic [2:0] cnt; // bytes left in the phase
		logic [7:0] data0; // first data byte
		logic tgl_seen; // last link toggle consumed
		logic cs_seen; // chip select level last clock
		logic mid_seen; // partial byte when frame ended
		logic complete; // frame holds a whole instruction
		logic latch; // write enable latch
		logic unlock; // status write unlocked
		logic auto_mode; // word programming in progress
		logic busy_out; // busy report on output enabled
		logic [3:0] bp; // block protection bits
		logic lock; // protection lock bit
		logic id_sel; // next ident byte is the part code
		logic [7:0] tx_byte; // next output byte for the link
		logic rd_req;
		logic prog_req;
		logic erase_req;
		logic [1:0] erase_kind;
		logic [7:0] prog_data;
		logic [ADDR_W-1:0] mem_addr;
		logic so_oe;
	} sfid_dec_s;

	sfid_dec_s st_reg;
	sfid_dec_s st_next;
	logic rst_meta_reg;
	logic rst_n_reg;
	logic cs_n_sync;
	logic tgl_sync;
	logic mid_sync;
	logic wp_n_sync; // protect pin after two flops
	logic [7:0] rx_byte;
	logic rx_tgl;
	logic mid_byte;
	logic [7:0] status;

	// ****************************************
	// reset release
	// ****************************************
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ****************************************
	// link side and crossings
	// ****************************************
	// status byte as the host sees it
	assign status = {st_reg.lock, st_reg.auto_mode, st_reg.bp, st_reg.latch, busy_in};

	sfid_link u_link (
		.sck_in(sck_in),
		.cs_n_in(cs_n_in),
		.si_in(si_in),
		.tx_byte_in(st_reg.tx_byte),
		.status_in(status),
		.rx_byte_out(rx_byte),
		.rx_tgl_out(rx_tgl),
		.mid_byte_out(mid_byte),
		.so_out(so_out)
	);
	// the byte word is read only after its toggle has settled, by which time it is still
	sfid_sync #(.INIT(1'b1)) u_cs_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_reg),
		.d_in(cs_n_in),
		.q_out(cs_n_sync)
	);
	sfid_sync #(.INIT(1'b0)) u_tgl_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_reg),
		.d_in(rx_tgl),
		.q_out(tgl_sync)
	);
	sfid_sync #(.INIT(1'b0)) u_mid_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_reg),
		.d_in(mid_byte),
		.q_out(mid_sync)
	);
	// protect pin comes from the board, never read before two flops
	sfid_sync #(.INIT(1'b1)) u_wp_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_reg),
		.d_in(wp_n_in),
		.q_out(wp_n_sync)
	);

	// address bits above the array width fall away here
	function automatic logic [ADDR_W-1:0] sfid_fold(input logic [ADDR_W-1:0] a,
		input logic [7:0] b);
		sfid_fold = {a[ADDR_W-9:0], b};
	endfunction

	// opcode needs three address bytes
	function automatic logic sfid_has_addr(input logic [7:0] op);
		sfid_has_addr = (op == SFID_OP_READ) || (op == SFID_OP_FAST_READ) ||
			(op == SFID_OP_SECTOR_ERASE) || (op == SFID_OP_BLOCK32_ERASE) ||
			(op == SFID_OP_BLOCK64_ERASE) || (op == SFID_OP_BYTE_PROG) ||
			(op == SFID_OP_IDENT_A) || (op == SFID_OP_IDENT_B) ||
			(op == SFID_OP_AUTO_INC);
	endfunction

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		logic new_byte;
		logic frame_end;
		new_byte = 1'b0;
		frame_end = 1'b0;
		st_next = st_reg;
		st_next.rd_req = 1'b0;
		st_next.prog_req = 1'b0;
		st_next.erase_req = 1'b0;
		st_next.cs_seen = cs_n_sync;
		st_next.tgl_seen = tgl_sync;
		new_byte = (tgl_sync != st_reg.tgl_seen) && !cs_n_sync;
		frame_end = cs_n_sync && !st_reg.cs_seen;
		if (!cs_n_sync) begin
			st_next.mid_seen = mid_sync;
		end
		// busy report while word programming, else output only when streaming
		st_next.so_oe = !cs_n_sync && ((st_reg.state == SFID_OUT) ||
			(st_reg.busy_out && st_reg.auto_mode));
		if (st_reg.busy_out && st_reg.auto_mode && st_reg.state == SFID_IDLE) begin
			st_next.tx_byte = busy_in ? 8'h00 : SFID_FILL_BYTE;
		end
		// fresh frame: the link side cleared its toggle while deselected
		if (!cs_n_sync && st_reg.cs_seen) begin
			st_next.tgl_seen = 1'b0;
			st_next.state = SFID_IDLE;
			st_next.complete = 1'b0;
			st_next.opcode = 8'h00;
			new_byte = tgl_sync;
		end
		if (new_byte) begin
			unique case (st_reg.state)
				SFID_IDLE: begin
					st_next.opcode = rx_byte;
					st_next.cnt = SFID_ADDR_BYTES;
					st_next.complete = 1'b1;
					st_next.state = SFID_IGNORE;
					if (st_reg.auto_mode && rx_byte == SFID_OP_AUTO_INC) begin
						// later words bring data only
						st_next.cnt = 3'h2;
						st_next.complete = 1'b0;
						st_next.state = SFID_DATA;
					end else if (sfid_has_addr(rx_byte)) begin
						st_next.complete = 1'b0;
						st_next.state = SFID_ADDR;
						st_next.tx_byte = SFID_FILL_BYTE;
					end else if (rx_byte == SFID_OP_STATUS_READ) begin
						st_next.tx_byte = status;
						st_next.state = SFID_OUT;
					end else if (rx_byte == SFID_OP_STATUS_WRITE) begin
						st_next.cnt = 3'h1;
						st_next.complete = 1'b0;
						st_next.state = SFID_DATA;
					end else if (rx_byte == SFID_OP_LATCH_SET ||
						rx_byte == SFID_OP_LATCH_CLEAR ||
						rx_byte == SFID_OP_STATUS_UNLOCK ||
						rx_byte == SFID_OP_CHIP_ERASE_A ||
						rx_byte == SFID_OP_CHIP_ERASE_B ||
						rx_byte == SFID_OP_BUSY_OUT_ON ||
						rx_byte == SFID_OP_BUSY_OUT_OFF) begin
						st_next.complete = 1'b1;
					end else begin
						// unknown opcode: stay quiet until the next frame
						st_next.complete = 1'b0;
					end
				end
				SFID_ADDR: begin
					st_next.addr = sfid_fold(st_reg.addr, rx_byte);
					st_next.cnt = st_reg.cnt - 3'h1;
					if (st_reg.cnt == 3'h1) begin
						if (st_reg.opcode == SFID_OP_READ) begin
							st_next.state = SFID_OUT;
							st_next.rd_req = 1'b1;
							st_next.mem_addr = sfid_fold(st_reg.addr, rx_byte);
						end else if (st_reg.opcode == SFID_OP_FAST_READ) begin
							st_next.state = SFID_DUMMY;
							st_next.rd_req = 1'b1;
							st_next.mem_addr = sfid_fold(st_reg.addr, rx_byte);
						end else if (st_reg.opcode == SFID_OP_IDENT_A ||
							st_reg.opcode == SFID_OP_IDENT_B) begin
							st_next.state = SFID_OUT;
							st_next.tx_byte = rx_byte[0] ? PART_CODE : MAKER_CODE;
							st_next.id_sel = ~rx_byte[0];
						end else if (st_reg.opcode == SFID_OP_BYTE_PROG) begin
							st_next.state = SFID_DATA;
							st_next.cnt = 3'h1;
						end else if (st_reg.opcode == SFID_OP_AUTO_INC) begin
							st_next.state = SFID_DATA;
							st_next.cnt = 3'h2;
						end else begin
							st_next.state = SFID_IGNORE;
							st_next.complete = 1'b1;
						end
					end
				end
				SFID_DUMMY: begin
					st_next.state = SFID_OUT;
					st_next.rd_req = 1'b1;
					st_next.addr = st_reg.addr + 1'b1;
					st_next.mem_addr = st_reg.addr + 1'b1;
				end
				SFID_DATA: begin
					st_next.data0 = rx_byte;
					st_next.cnt = st_reg.cnt - 3'h1;
					if (st_reg.cnt == 3'h1) begin
						st_next.state = SFID_IGNORE;
						st_next.complete = 1'b1;
					end
				end
				SFID_OUT: begin
					// each whole byte clocked out queues the next one
					if (st_reg.opcode == SFID_OP_STATUS_READ) begin
						st_next.tx_byte = status;
					end else if (st_reg.opcode == SFID_OP_READ ||
						st_reg.opcode == SFID_OP_FAST_READ) begin
						st_next.rd_req = 1'b1;
						st_next.addr = st_reg.addr + 1'b1;
						st_next.mem_addr = st_reg.addr + 1'b1;
					end else begin
						st_next.tx_byte = st_reg.id_sel ? PART_CODE : MAKER_CODE;
						st_next.id_sel = ~st_reg.id_sel;
					end
				end
				SFID_IGNORE: begin
					// extra bytes void the instruction
					st_next.complete = 1'b0;
				end
			endcase
		end
		// read data lands one clock after its request
		if (st_reg.rd_req) begin
			st_next.tx_byte = mem_rd_data_in;
		end
		// ****************************************
		// execute at deselect, only on a whole instruction; word programming runs as its data bytes arrive
		// ****************************************
		if (frame_end && st_reg.complete && !st_reg.mid_seen) begin
			st_next.state = SFID_IDLE;
			unique case (st_reg.opcode)
				SFID_OP_LATCH_SET: st_next.latch = 1'b1;
				SFID_OP_LATCH_CLEAR: begin
					st_next.latch = 1'b0;
					st_next.auto_mode = 1'b0;
				end
				SFID_OP_STATUS_UNLOCK: st_next.unlock = 1'b1;
				SFID_OP_BUSY_OUT_ON: st_next.busy_out = 1'b1;
				SFID_OP_BUSY_OUT_OFF: begin
					if (!st_reg.auto_mode) begin
						st_next.busy_out = 1'b0;
					end
				end
				SFID_OP_STATUS_WRITE: begin
					if ((st_reg.latch || st_reg.unlock) &&
						!(!wp_n_sync && st_reg.lock)) begin
						st_next.bp = st_reg.data0[SFID_ST_BP_LSB +: 4];
						st_next.lock = st_reg.data0[SFID_ST_LOCK];
					end
					st_next.latch = 1'b0;
					st_next.unlock = 1'b0;
				end
				SFID_OP_SECTOR_ERASE, SFID_OP_BLOCK32_ERASE, SFID_OP_BLOCK64_ERASE,
				SFID_OP_CHIP_ERASE_A, SFID_OP_CHIP_ERASE_B: begin
					st_next.erase_req = st_reg.latch;
					st_next.latch = 1'b0;
					st_next.mem_addr = st_reg.addr;
					if (st_reg.opcode == SFID_OP_SECTOR_ERASE) begin
						st_next.erase_kind = SFID_ER_SECTOR;
						st_next.mem_addr[SFID_SECTOR_LSB-1:0] = '0;
					end else if (st_reg.opcode == SFID_OP_BLOCK32_ERASE) begin
						st_next.erase_kind = SFID_ER_BLOCK32;
						st_next.mem_addr[SFID_BLOCK32_LSB-1:0] = '0;
					end else if (st_reg.opcode == SFID_OP_BLOCK64_ERASE) begin
						st_next.erase_kind = SFID_ER_BLOCK64;
						st_next.mem_addr[SFID_BLOCK64_LSB-1:0] = '0;
					end else begin
						st_next.erase_kind = SFID_ER_CHIP;
						st_next.mem_addr = '0;
					end
				end
				SFID_OP_BYTE_PROG: begin
					st_next.prog_req = st_reg.latch;
					st_next.prog_data = st_reg.data0;
					st_next.mem_addr = st_reg.addr;
					st_next.latch = 1'b0;
				end
				default: begin
				end
			endcase
		end else if (frame_end) begin
			st_next.state = SFID_IDLE;
		end
		// word programming: first byte even, second byte odd address
		if (new_byte && st_reg.state == SFID_DATA && st_reg.cnt == 3'h1 &&
			(st_reg.opcode == SFID_OP_AUTO_INC) && (st_reg.latch || st_reg.auto_mode)) begin
			st_next.auto_mode = 1'b1;
			st_next.prog_req = 1'b1;
			st_next.prog_data = st_reg.data0;
			st_next.mem_addr = {st_reg.addr[ADDR_W-1:1], 1'b0};
		end
		if (st_reg.prog_req && st_reg.auto_mode && st_reg.mem_addr[0] == 1'b0 &&
			st_reg.state != SFID_DATA) begin
			st_next.prog_req = 1'b1;
			st_next.prog_data = rx_byte;
			st_next.mem_addr = {st_reg.addr[ADDR_W-1:1], 1'b1};
			st_next.addr = {st_reg.addr[ADDR_W-1:1], 1'b0} + 2'h2;
			if (&st_reg.addr[ADDR_W-1:1]) begin
				// top of the array ends word programming, no wrap
				st_next.auto_mode = 1'b0;
				st_next.latch = 1'b0;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			st_reg <= '0;
			st_reg.state <= SFID_IDLE;
			st_reg.cs_seen <= 1'b1;
			st_reg.bp <= SFID_BP_RESET;
			st_reg.tx_byte <= SFID_FILL_BYTE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign so_oe_out = st_reg.so_oe;
	assign mem_rd_req_out = st_reg.rd_req;
	assign mem_addr_out = st_reg.mem_addr;
	assign prog_req_out = st_reg.prog_req;
	assign prog_data_out = st_reg.prog_data;
	assign erase_req_out = st_reg.erase_req;
	assign erase_kind_out = st_reg.erase_kind;
	assign write_enable_latch_out = st_reg.latch;
	assign status_out = {st_reg.lock, st_reg.auto_mode, st_reg.bp, st_reg.latch, 1'b0};

	// ****************************************
	// checks
	// ****************************************
	property p_erase_needs_latch;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		st_reg.erase_req |-> $past(st_reg.latch) && !st_reg.latch;
	endproperty
	a_erase_needs_latch: assert property (p_erase_needs_latch)
		else $error("erase issued without write latch");

	property p_sector_align;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		st_reg.erase_req && st_reg.erase_kind == SFID_ER_SECTOR
			|-> st_reg.mem_addr[SFID_SECTOR_LSB-1:0] == '0;
	endproperty
	a_sector_align: assert property (p_sector_align)
		else $error("sector erase address not aligned");

	property p_status_locked;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		(!wp_n_sync && st_reg.lock) |=> $stable(st_reg.bp) && st_reg.lock;
	endproperty
	a_status_locked: assert property (p_status_locked)
		else $error("locked status changed");

	property p_no_exec_when_selected;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		(st_reg.erase_req || (st_reg.prog_req && !st_reg.auto_mode)) |-> st_reg.cs_seen;
	endproperty
	a_no_exec_when_selected: assert property (p_no_exec_when_selected)
		else $error("write executed while selected");

	// word programming writes the even byte, then the odd byte on the next clock
	sequence s_even_prog;
		st_reg.prog_req && st_reg.auto_mode && !st_reg.mem_addr[0];
	endsequence
	sequence s_odd_prog;
		st_reg.prog_req && st_reg.mem_addr[0];
	endsequence
	property p_word_pair;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		s_even_prog |=> s_odd_prog;
	endproperty
	a_word_pair: assert property (p_word_pair)
		else $error("word programming lost its odd byte");

	property p_block64_align;
		@(posedge mclk_in) disable iff (!rst_n_reg)
		st_reg.erase_req && st_reg.erase_kind == SFID_ER_BLOCK64
			|-> st_reg.mem_addr[SFID_BLOCK64_LSB-1:0] == '0;
	endproperty
	a_block64_align: assert property (p_block64_align)
		else $error("large block erase address not aligned");
endmodule

/* File: testbench/sfid_host.sv */
// host spi controller model: drives chip select, serial clock and serial input
// assumes mode 0, with the serial clock standing low outside frames
module sfid_host (
	output logic sck_out,
	output logic cs_n_out,
	output logic si_out,
	input wire logic so_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] tx[16]; // bytes to send
	logic [7:0] rx[16]; // bytes seen on serial output
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end
	// n whole bytes, then nb bits of one more to cut a cycle short
	task automatic frame(input int n, input int nb);
		int j;
		cs_n_out = 1'b0;
		for (j = 0; j < 8 * n + nb; j++) begin
			si_out = tx[j / 8][7 - j % 8];
			#16 sck_out = 1'b1;
			rx[j / 8] = {rx[j / 8][6:0], so_in};
			#16 sck_out = 1'b0;
		end
		#16 cs_n_out = 1'b1;
		// released input shows no stale level
		si_out = ~si_out;
		#80;
	endtask
endmodule

/* File: testbench/serial_flash_instruction_decoder_tb_top.sv */
// self-checking bench for the instruction decoder
// assumes the host model above and a tiny array answering reads one clock late
module serial_flash_instruction_decoder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sfid_pkg::*;
	localparam logic [7:0] MK = 8'h3A; // arbitrary value
	localparam logic [7:0] PT = 8'hC5; // arbitrary value
	logic mclk_in, arst_n_in, busy_in, sck, cs_n, si, so, prq, erq, write_enable_latch, wp_n;
	logic [7:0] rd_d = 8'h00, pd, st;
	logic [23:0] ad, a;
	logic [1:0] ek;
	logic [34:0] q[$];
	int n_fail, n_tests, i;
	logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
	int lsb[5] = '{12, 15, 16, 24, 24};
	sfid_host h (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so));
	sfid_decoder #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (.mclk_in(mclk_in),
		.arst_n_in(arst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n),
		.busy_in(busy_in), .mem_rd_data_in(rd_d), .so_out(so), .so_oe_out(),
		.mem_rd_req_out(prq), .mem_addr_out(ad), .prog_req_out(), .prog_data_out(pd),
		.erase_req_out(erq), .erase_kind_out(ek), .write_enable_latch_out(write_enable_latch),
		.status_out(st));
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	// array read model: answers inside the request cycle, where the decoder takes it
	always @(negedge mclk_in) if (prq) rd_d <= ad[7:0] ^ 8'h3C;
	task automatic check(input string nm, input logic [34:0] seen, input logic [34:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// watcher: each pulse takes the oldest note; a pulse with no note is a fault
	always @(posedge mclk_in) begin
		if (uut.prog_req_out === 1'b1 || erq === 1'b1) begin
			if (q.size() == 0) check("pulse", 35'h1, 35'h0);
			else check("pulse", {erq, erq ? ek : 2'h0, (erq && ek == 2'h3) ? 24'h0 : ad,
				erq ? 8'h0 : pd}, q.pop_front());
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic send(input int n, input int nb);
		@(posedge mclk_in);
		#1 h.frame(n, nb);
	endtask
	// bounded wait for the watcher to use up every note
	task automatic settle;
		for (int k = 0; k < 40 && q.size() != 0; k++) @(posedge mclk_in);
		if (q.size() != 0) begin
			n_fail++;
			complete_run;
		end
	endtask
	task automatic latch_set;
		h.tx[0] = SFID_OP_LATCH_SET;
		send(1, 0);
		check("latch", 35'(write_enable_latch), 35'h1);
	endtask
	task automatic hdr(input logic [7:0] op);
		a = 24'($urandom);
		h.tx[0] = op;
		{h.tx[1], h.tx[2], h.tx[3]} = a;
	endtask
	initial begin
		arst_n_in = 1'b0;
		busy_in = 1'b0;
		wp_n = 1'b1;
		void'($urandom(32'hac0ff18c));
		repeat (2) @(posedge mclk_in);
		#1 arst_n_in = 1'b1;
		repeat (4) @(posedge mclk_in);
		check("status", 35'(st), 35'h1C);
		// every erase kind, low address bits dropped
		for (i = 0; i < 5; i++) begin
			latch_set;
			hdr(ops[i]);
			q.push_back({1'b1, i < 3 ? 2'(i) : 2'h3, a & (24'hFF_FFFF << lsb[i]), 8'h0});
			send(i < 3 ? 4 : 1, 0);
			settle;
			check("latch", 35'(write_enable_latch), 35'h0);
		end
		$display("erase test done");
		// byte program, then refused without latch, then cut short mid byte
		latch_set;
		hdr(SFID_OP_BYTE_PROG);
		h.tx[4] = 8'($urandom);
		q.push_back({3'h0, a, h.tx[4]});
		send(5, 0);
		settle;
		check("latch", 35'(write_enable_latch), 35'h0);
		send(5, 0);
		latch_set;
		h.tx[0] = SFID_OP_BYTE_PROG;
		send(4, 7);
		repeat (20) @(posedge mclk_in);
		check("cut", 35'(write_enable_latch), 35'h1);
		$display("program test done");
		// auto increment: two words, even then odd address
		hdr(SFID_OP_AUTO_INC);
		{h.tx[4], h.tx[5]} = 16'($urandom);
		q.push_back({3'h0, a[23:1], 1'b0, h.tx[4]});
		q.push_back({3'h0, a[23:1], 1'b1, h.tx[5]});
		send(6, 0);
		settle;
		h.tx[1] = 8'h5E;
		h.tx[2] = 8'h91;
		q.push_back({3'h0, a[23:1] + 23'h1, 1'b0, 8'h5E});
		q.push_back({3'h0, a[23:1] + 23'h1, 1'b1, 8'h91});
		send(3, 0);
		settle;
		h.tx[0] = SFID_OP_LATCH_CLEAR;
		send(1, 0);
		check("latch", 35'(write_enable_latch), 35'h0);
		check("auto_end", 35'(st), 35'h1C);
		$display("auto test done");
		// status write: taken, refused while pin low and locked, then unlocked by 50h
		latch_set;
		h.tx[0] = SFID_OP_STATUS_WRITE;
		h.tx[1] = 8'h84;
		send(2, 0);
		check("status_write_cmd", 35'(st), 35'h84);
		wp_n = 1'b0;
		latch_set;
		h.tx[0] = SFID_OP_STATUS_WRITE;
		h.tx[1] = 8'h00;
		send(2, 0);
		check("locked", 35'(st), 35'h84);
		wp_n = 1'b1;
		h.tx[0] = SFID_OP_STATUS_UNLOCK;
		send(1, 0);
		h.tx[0] = SFID_OP_STATUS_WRITE;
		h.tx[1] = 8'h1C;
		send(2, 0);
		check("unlock", 35'(st), 35'h1C);
		$display("status write test done");
		// status repeats each byte with busy and latch shown
		busy_in = 1'b1;
		latch_set;
		h.tx[0] = SFID_OP_STATUS_READ;
		send(3, 0);
		check("status1", 35'(h.rx[1]), 35'h1F);
		check("status2", 35'(h.rx[2]), 35'h1F);
		busy_in = 1'b0;
		// fast read with dummy byte, then both ident orders
		hdr(SFID_OP_FAST_READ);
		send(6, 0);
		check("fast", 35'(h.rx[5]), 35'(a[7:0] ^ 8'h3C));
		h.tx[1] = 8'h00;
		h.tx[2] = 8'h00;
		for (i = 0; i < 2; i++) begin
			h.tx[0] = i ? SFID_OP_IDENT_B : SFID_OP_IDENT_A;
			h.tx[3] = 8'(i);
			send(7, 0);
			check("ident", 35'(h.rx[5]), 35'(i ? PT : MK));
			check("ident2", 35'(h.rx[6]), 35'(i ? MK : PT));
		end
		$display("read test done");
		complete_run;
	end
endmodule
